//--- src/bcgc_pkg.sv
// package of constants for the buck charger gate control
package bcgc_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SS_STEPS = 8;
    localparam int unsigned SS_STEP_US = 1600;
    localparam int unsigned SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
    localparam int unsigned SW_PERIOD_CYC = 166;
    localparam int unsigned DUTY_MAX_PERMIL = 995;
    localparam int unsigned DUTY_MAX_CYC = (SW_PERIOD_CYC * DUTY_MAX_PERMIL) / 1000;
    localparam int unsigned DEAD_NS = 30;
    localparam int unsigned DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned REFRESH_NS = 80;
    localparam int unsigned REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
    localparam int unsigned BOOT_LOW_CYCLES = 3;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned TGT_W = 8;
    localparam int unsigned FLAG_W = 7;
    localparam logic [FLAG_W-1:0] FLAG_RST = 7'h00;
    typedef enum logic [1:0] {
        BCGC_OFF,
        BCGC_HIGH,
        BCGC_DEAD,
        BCGC_LOW
    } bcgc_phase_t;
endpackage : bcgc_pkg

//--- src/bcgc_flag_if.sv
// interface carrying synchronised comparator flags
`timescale 1ns/1ns
interface bcgc_flag_if;
    logic [bcgc_pkg::FLAG_W-1:0] flags;
    modport src (output flags);
    modport dst (input flags);
endinterface : bcgc_flag_if

//--- src/bcgc_sync.sv
// two-stage synchroniser for the comparator flags
`timescale 1ns/1ns
module bcgc_sync (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [bcgc_pkg::FLAG_W-1:0] raw,
    bcgc_flag_if.src out
);
    import bcgc_pkg::*;
    logic [FLAG_W-1:0] meta_r;
    logic [FLAG_W-1:0] sync_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_r <= FLAG_RST;
            sync_r <= FLAG_RST;
        end else if (CE) begin
            meta_r <= raw;
            sync_r <= meta_r;
        end
    end
    assign out.flags = sync_r;
endmodule : bcgc_sync

//--- src/bcgc_top.sv
// gate sequencing for the synchronous buck charger
// Behaviour
// - soft-start target in eight 1.6ms steps
// - zero duty below ramp, full above
// - cap high-side duty near 99.5 percent
// - bootstrap low three cycles forces refresh
// - sense above 5mV gives synchronous switching
// - 30ns dead time between gate transitions
// - below 5mV, low battery, low average: non-sync
// - DCM bootstrap low gives 80ns low pulse
// - zero duty keeps high gate off; low gate stays on in sync mode
// - sense drop ends low-side for cycle
// - over-voltage disables charge, selects battery
// - cycles from fixed oscillator only
`timescale 1ns/1ns
module bcgc_top #(
    parameter int unsigned TGT_PROG = 255,
    parameter int unsigned STEP_CYC = bcgc_pkg::SS_STEP_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic FAST_CHARGE,
    input wire logic PWM_DEMAND,
    input wire logic ERR_ABOVE_PEAK,
    input wire logic ERR_BELOW_RAMP,
    input wire logic SENSE_ABOVE_5MV,
    input wire logic SENSE_AVG_LOW,
    input wire logic BATTERY_BELOW_2V,
    input wire logic BOOTSTRAP_LOW,
    input wire logic INPUT_OVERVOLTAGE,
    output logic HIGH_GATE,
    output logic LOW_GATE,
    output logic CHARGE_ENABLE,
    output logic BATTERY_PATH,
    output logic SYNC_MODE,
    output logic [bcgc_pkg::TGT_W-1:0] CURRENT_TARGET
);
    import bcgc_pkg::*;
    bcgc_flag_if fl ();
    logic [FLAG_W-1:0] raw;
    assign raw = {INPUT_OVERVOLTAGE, BOOTSTRAP_LOW, BATTERY_BELOW_2V, SENSE_AVG_LOW,
                  SENSE_ABOVE_5MV, ERR_BELOW_RAMP, ERR_ABOVE_PEAK};
    bcgc_sync u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .CE(CE),
        .raw(raw),
        .out(fl)
    );
    logic above_peak, below_ramp, sense_ok, avg_low, bat_low, boot_low, ovp;
    assign above_peak = fl.flags[0];
    assign below_ramp = fl.flags[1];
    assign sense_ok = fl.flags[2];
    assign avg_low = fl.flags[3];
    assign bat_low = fl.flags[4];
    assign boot_low = fl.flags[5];
    assign ovp = fl.flags[6];

    logic [CNT_W-1:0] per_r;
    logic cyc_start;
    assign cyc_start = (per_r == CNT_W'(SW_PERIOD_CYC - 1));
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            per_r <= '0;
        end else if (CE) begin
            per_r <= cyc_start ? '0 : per_r + 1'b1;
        end
    end

    logic chg_en;
    assign chg_en = !ovp;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CHARGE_ENABLE <= 1'b0;
            BATTERY_PATH <= 1'b1;
        end else if (CE) begin
            CHARGE_ENABLE <= chg_en;
            BATTERY_PATH <= ovp;
        end
    end

    logic fc_d_r;
    logic [3:0] step_r;
    logic [31:0] step_cnt_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fc_d_r <= 1'b0;
            step_r <= '0;
            step_cnt_r <= '0;
        end else if (CE) begin
            fc_d_r <= FAST_CHARGE && chg_en;
            if (!(FAST_CHARGE && chg_en) || !fc_d_r) begin
                step_r <= '0;
                step_cnt_r <= '0;
            // last step holds; one more would wrap the target
            end else if (step_r < 4'(SS_STEPS - 1)) begin
                if (step_cnt_r == STEP_CYC - 1) begin
                    step_cnt_r <= '0;
                    step_r <= step_r + 1'b1;
                end else begin
                    step_cnt_r <= step_cnt_r + 1'b1;
                end
            end
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CURRENT_TARGET <= '0;
        end else if (CE) begin
            CURRENT_TARGET <= TGT_W'((TGT_PROG * (32'(step_r) + 1)) / SS_STEPS);
            if (!fc_d_r) begin
                CURRENT_TARGET <= '0;
            end
        end
    end

    logic sync_mode;
    assign sync_mode = sense_ok && !bat_low && !avg_low;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SYNC_MODE <= 1'b0;
        end else if (CE) begin
            SYNC_MODE <= sync_mode;
        end
    end

    logic [1:0] boot_cyc_r;
    logic force_refresh;
    assign force_refresh = (boot_cyc_r == 2'(BOOT_LOW_CYCLES)) && boot_low;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            boot_cyc_r <= '0;
        end else if (CE && cyc_start) begin
            if (!boot_low) begin
                boot_cyc_r <= '0;
            end else if (boot_cyc_r != 2'(BOOT_LOW_CYCLES)) begin
                boot_cyc_r <= boot_cyc_r + 1'b1;
            end
        end
    end

    logic high_req;
    always_comb begin
        high_req = 1'b0;
        if (!chg_en || below_ramp) begin
            high_req = 1'b0;
        end else if (above_peak || PWM_DEMAND) begin
            // limit leaves the high side off for one count of every period
            high_req = per_r < CNT_W'(DUTY_MAX_CYC);
        end
    end

    // under-current cut for rest of cycle
    logic low_cut_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_cut_r <= 1'b0;
        end else if (CE) begin
            // a drop on the period edge still cuts: set wins over the clear
            if (!sense_ok) begin
                low_cut_r <= 1'b1;
            end else if (cyc_start) begin
                low_cut_r <= 1'b0;
            end
        end
    end

    logic refresh_done_r;
    logic [CNT_W-1:0] ph_cnt_r;
    bcgc_phase_t phase_r;
    logic want_low;
    assign want_low = chg_en && sync_mode && !low_cut_r && !high_req;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            refresh_done_r <= 1'b0;
        end else if (CE) begin
            if (cyc_start) begin
                refresh_done_r <= 1'b0;
            end else if (phase_r == BCGC_LOW && !want_low) begin
                refresh_done_r <= 1'b1;
            end
        end
    end
    logic want_refresh;
    // forced refresh must not wait for the high request to drop under full duty
    assign want_refresh = chg_en && !refresh_done_r
                          && (force_refresh || (boot_low && !high_req));

    logic pulse_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_r <= BCGC_OFF;
            ph_cnt_r <= '0;
            pulse_r <= 1'b0;
        end else if (CE) begin
            ph_cnt_r <= ph_cnt_r + 1'b1;
            unique case (phase_r)
                BCGC_OFF: begin
                    if (high_req && !force_refresh) begin
                        phase_r <= BCGC_HIGH;
                    end else if (want_low || want_refresh) begin
                        phase_r <= BCGC_LOW;
                        ph_cnt_r <= '0;
                        // refresh entry runs the full pulse even after the flag clears
                        pulse_r <= !want_low;
                    end
                end
                BCGC_HIGH: begin
                    if (!high_req || force_refresh) begin
                        phase_r <= BCGC_DEAD;
                        ph_cnt_r <= '0;
                    end
                end
                BCGC_DEAD: begin
                    if (ph_cnt_r >= CNT_W'(DEAD_CYC - 1)) begin
                        phase_r <= BCGC_OFF;
                    end
                end
                BCGC_LOW: begin
                    if (!want_low && (!pulse_r || ph_cnt_r >= CNT_W'(REFRESH_CYC - 1))) begin
                        phase_r <= BCGC_DEAD;
                        ph_cnt_r <= '0;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HIGH_GATE <= 1'b0;
            LOW_GATE <= 1'b0;
        end else if (CE) begin
            HIGH_GATE <= (phase_r == BCGC_HIGH) && high_req && !force_refresh;
            LOW_GATE <= (phase_r == BCGC_LOW) && chg_en;
        end
    end
endmodule : bcgc_top

//--- tb/bcgc_fet_model.sv
// external fets with a bootstrap capacitor that drains
`timescale 1ns/1ns
module bcgc_fet_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic high_gate,
    input wire logic low_gate,
    output logic boot_low
);
    logic [9:0] drain_r;
    // low side recharges, high side drains
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drain_r <= 10'h000;
        end else if (low_gate) begin
            drain_r <= 10'h000;
        end else if (high_gate && drain_r != 10'h3ff) begin
            drain_r <= drain_r + 10'h001;
        end
    end
    // low after about two full periods of high side
    assign boot_low = drain_r > 10'h12c;
endmodule : bcgc_fet_model

//--- tb/bcgc_assertions.sv
// port checker for the gate control
`timescale 1ns/1ns
module bcgc_assertions #(
    parameter int unsigned TGT_PROG = 255,
    parameter int unsigned STEP_CYC = 20
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic FAST_CHARGE,
    input wire logic PWM_DEMAND,
    input wire logic ERR_ABOVE_PEAK,
    input wire logic ERR_BELOW_RAMP,
    input wire logic SENSE_ABOVE_5MV,
    input wire logic SENSE_AVG_LOW,
    input wire logic BATTERY_BELOW_2V,
    input wire logic BOOTSTRAP_LOW,
    input wire logic INPUT_OVERVOLTAGE,
    input wire logic HIGH_GATE,
    input wire logic LOW_GATE,
    input wire logic CHARGE_ENABLE,
    input wire logic BATTERY_PATH,
    input wire logic SYNC_MODE,
    input wire logic [bcgc_pkg::TGT_W-1:0] CURRENT_TARGET
);
    import bcgc_pkg::*;
    logic [7:0] hi_run_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hi_run_r <= 8'h00;
        end else if (CE) begin
            hi_run_r <= HIGH_GATE ? hi_run_r + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    // frozen cycles are not judged
    default disable iff (!RST_N || !CE);
    sequence sense_ok;
        (SENSE_ABOVE_5MV && !SENSE_AVG_LOW && !BATTERY_BELOW_2V && CHARGE_ENABLE) [*6];
    endsequence
    sequence low_pulse;
        LOW_GATE [*8] ##1 !LOW_GATE;
    endsequence
    gates_apart_a: assert property (!(HIGH_GATE && LOW_GATE))
        else $error("both gates on");
    dead_hl_a: assert property ($fell(HIGH_GATE) |-> !LOW_GATE [*3])
        else $error("short dead time after high");
    dead_lh_a: assert property ($fell(LOW_GATE) |-> !HIGH_GATE [*3])
        else $error("short dead time after low");
    duty_cap_a: assert property (HIGH_GATE |-> hi_run_r < 8'(SW_PERIOD_CYC - 1))
        else $error("high side run too long");
    ov_stop_a: assert property (INPUT_OVERVOLTAGE [*5] |->
        !CHARGE_ENABLE && BATTERY_PATH && !HIGH_GATE) else $error("overvoltage ignored");
    flag_sync_a: assert property ($rose(INPUT_OVERVOLTAGE) && CHARGE_ENABLE |->
        CHARGE_ENABLE [*3]) else $error("flag used unsynchronised");
    target_hold_a: assert property (CURRENT_TARGET == TGT_W'(TGT_PROG) && FAST_CHARGE
        && !INPUT_OVERVOLTAGE |=> CURRENT_TARGET == TGT_W'(TGT_PROG))
        else $error("soft-start target left full");
    ramp_off_a: assert property (ERR_BELOW_RAMP [*5] |-> !HIGH_GATE)
        else $error("duty below ramp");
    sync_on_a: assert property (sense_ok |-> SYNC_MODE)
        else $error("sync mode missing");
    async_forced_a: assert property ((BATTERY_BELOW_2V || SENSE_AVG_LOW
        || !SENSE_ABOVE_5MV) [*6] |-> !SYNC_MODE) else $error("sync mode not left");
    refresh_len_a: assert property ($rose(LOW_GATE) && !SYNC_MODE
        && !SENSE_ABOVE_5MV && !$past(SENSE_ABOVE_5MV, 4) |-> low_pulse)
        else $error("refresh pulse length");
endmodule : bcgc_assertions
bind bcgc_top bcgc_assertions #(.TGT_PROG(TGT_PROG), .STEP_CYC(STEP_CYC)) i_bcgc_assertions (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .FAST_CHARGE(FAST_CHARGE), .PWM_DEMAND(PWM_DEMAND),
    .ERR_ABOVE_PEAK(ERR_ABOVE_PEAK), .ERR_BELOW_RAMP(ERR_BELOW_RAMP),
    .SENSE_ABOVE_5MV(SENSE_ABOVE_5MV), .SENSE_AVG_LOW(SENSE_AVG_LOW),
    .BATTERY_BELOW_2V(BATTERY_BELOW_2V), .BOOTSTRAP_LOW(BOOTSTRAP_LOW),
    .INPUT_OVERVOLTAGE(INPUT_OVERVOLTAGE), .HIGH_GATE(HIGH_GATE), .LOW_GATE(LOW_GATE),
    .CHARGE_ENABLE(CHARGE_ENABLE), .BATTERY_PATH(BATTERY_PATH), .SYNC_MODE(SYNC_MODE),
    .CURRENT_TARGET(CURRENT_TARGET));

//--- tb/tb_top.sv
// self-checking bench for the gate control
`timescale 1ns/1ns
module tb_top;
    import bcgc_pkg::*;
    typedef struct packed {logic ov, avg, sense, bat, en_x, bp_x, sm_x;} bcgc_row_t;
    // mode rows: flags in, enable, battery path, sync out
    bcgc_row_t rows [5] = '{7'h15, 7'h04, 7'h1c, 7'h34, 7'h42};
    logic clk, rst_n, fast, pwm, peak, bramp, sense, avg, bat, boot, ov;
    logic hg, lg, chg_en, bat_path, sync_m, lg_d;
    logic ce = 1'b1, per_on = 1'b0, hg_d = 1'b0;
    logic [7:0] tgt, frz;
    int n_errors = 0, n_compared = 0, n_lg = 0, n0, run = 0, max_run = 0;
    int cyc = 0, last_fall = 0;
    bcgc_top #(.TGT_PROG(255), .STEP_CYC(20)) i_bcgc_top (.CLK(clk), .RST_N(rst_n),
        .CE(ce), .FAST_CHARGE(fast), .PWM_DEMAND(pwm), .ERR_ABOVE_PEAK(peak),
        .ERR_BELOW_RAMP(bramp), .SENSE_ABOVE_5MV(sense), .SENSE_AVG_LOW(avg),
        .BATTERY_BELOW_2V(bat), .BOOTSTRAP_LOW(boot), .INPUT_OVERVOLTAGE(ov), .HIGH_GATE(hg),
        .LOW_GATE(lg), .CHARGE_ENABLE(chg_en), .BATTERY_PATH(bat_path), .SYNC_MODE(sync_m),
        .CURRENT_TARGET(tgt));
    bcgc_fet_model i_bcgc_fet_model (.clk(clk), .rst_n(rst_n), .high_gate(hg), .low_gate(lg),
        .boot_low(boot));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // sampled before the edge's own updates land, so no race
    always @(posedge clk) begin
        run = hg ? run + 1 : 0;
        max_run = run > max_run ? run : max_run;
        n_lg = (lg && !lg_d) ? n_lg + 1 : n_lg;
        lg_d = lg;
        cyc++;
        // high side always ends at the same period phase
        if (hg_d && !hg) begin
            if (per_on && last_fall > 0) begin
                chk("period", 8'(cyc - last_fall), 8'(SW_PERIOD_CYC));
            end
            last_fall = cyc;
        end
        hg_d = hg;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rst_n, fast, pwm, peak, bramp, sense, avg, bat, ov, lg_d} = 10'h000;
        repeat (5) @(posedge clk);
        chk("path", 8'(bat_path), 8'h01);
        chk("target", tgt, 8'h00);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        fast <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            repeat (k == 0 ? 12 : 20) @(posedge clk);
            @(negedge clk);
            chk("target", tgt, 8'(255 * (k + 1) / 8));
        end
        foreach (rows[i]) begin
            @(posedge clk);
            {ov, avg, sense, bat} <= rows[i][6:3];
            repeat (12) @(posedge clk);
            @(negedge clk);
            chk("charge_en", 8'(chg_en), 8'(rows[i].en_x));
            chk("bat_path", 8'(bat_path), 8'(rows[i].bp_x));
            chk("sync", 8'(sync_m), 8'(rows[i].sm_x));
        end
        @(posedge clk);
        {ov, pwm, bramp} <= 3'h3;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("high_gate", 8'(hg), 8'h00);
        n0 = n_lg;
        max_run = 0;
        last_fall = 0;
        per_on = 1'b1;
        @(posedge clk);
        {bramp, peak} <= 2'h1;
        repeat (1500) @(posedge clk);
        @(negedge clk);
        chk("refresh", 8'(n_lg != n0), 8'h01);
        chk("duty_cap", 8'(max_run > 150 && max_run < 166), 8'h01);
        per_on = 1'b0;
        // frozen clock enable: outputs hold and the overvoltage flag is not taken
        @(posedge clk);
        {ce, ov} <= 2'h1;
        @(negedge clk);
        frz = {3'h0, hg, lg, chg_en, bat_path, sync_m};
        repeat (200) @(posedge clk);
        @(negedge clk);
        chk("freeze", {3'h0, hg, lg, chg_en, bat_path, sync_m}, frz);
        @(posedge clk);
        ce <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("ov_path", {6'h00, chg_en, bat_path}, 8'h01);
        report_and_stop();
    end
endmodule : tb_top
